//--- mpwm_unit.sv
// module: top of the match based pwm unit with timer, prescaler and register port
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module mpwm_unit #(
    parameter int CNT_W = mpwm_pkg::CNT_W,
    parameter int NUM_MATCH = mpwm_pkg::NUM_MATCH
) (
    input wire logic clk, // core clock
    input wire logic rst, // sync reset, active high
    input wire logic [5:0] regAddr, // register byte address
    input wire logic [31:0] regWdata, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    output logic [31:0] regRdata, // read data, cycle after strobe
    output logic [mpwm_pkg::NUM_OUT-1:0] pwmOut, // pwm outputs 1..6
    output logic matchIrq // any flagged match pending
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] preCount;
    logic [CNT_W-1:0] prescale;
    logic [3:0] timerCtrl;
    logic [NUM_MATCH*mpwm_pkg::MC_FIELD_W-1:0] matchCtrl;
    logic [NUM_MATCH-1:0] matchFlags;
    logic [15:0] pwmCtrl;
    logic [NUM_MATCH-1:0] releaseMask;
    logic [CNT_W-1:0] shadow [NUM_MATCH];
    logic [CNT_W-1:0] active [NUM_MATCH];
    logic [NUM_MATCH-1:0] hit;
    logic [NUM_MATCH-1:0] hitEvt;
    logic [31:0] next_rdata;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic runEn = timerCtrl[mpwm_pkg::TC_ENABLE_BIT];
    wire logic cntReset = timerCtrl[mpwm_pkg::TC_RESET_BIT];
    wire logic pwmMode = timerCtrl[mpwm_pkg::TC_PWM_BIT];
    wire logic tick = runEn && !cntReset && (preCount == prescale);
    wire logic wrTimer = regWr && regAddr == mpwm_pkg::OFF_TIMER_CTRL;
    wire logic wrCount = regWr && regAddr == mpwm_pkg::OFF_COUNT;
    wire logic wrPre = regWr && regAddr == mpwm_pkg::OFF_PRESCALE;
    wire logic wrMctl = regWr && regAddr == mpwm_pkg::OFF_MATCH_CTRL;
    wire logic wrFlags = regWr && regAddr == mpwm_pkg::OFF_MATCH_FLAGS;
    wire logic wrPwm = regWr && regAddr == mpwm_pkg::OFF_PWM_CTRL;
    wire logic wrRel = regWr && regAddr == mpwm_pkg::OFF_RELEASE;
    wire logic matchArea = regAddr >= mpwm_pkg::OFF_MATCH_BASE;
    wire logic [2:0] matchIdx = regAddr[4:2];
    wire logic wrMatch = regWr && matchArea && (matchIdx < 3'(NUM_MATCH));
    // hits only count on the tick in which the counter holds that value
    logic [NUM_MATCH-1:0] resetSel;
    logic [NUM_MATCH-1:0] stopSel;
    wire logic cycleStart = hitEvt[0] && pwmMode;
    wire logic anyReset = |(hitEvt & resetSel);
    wire logic anyStop = |(hitEvt & stopSel);

    // ------------------------------------------------------------
    // per-match compare, shadow and release
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_MATCH; g++) begin : gMatch
            assign hit[g] = (count == active[g]);
            assign hitEvt[g] = hit[g] && tick;
            // in pwm mode the cycle match always resets the counter
            assign resetSel[g] = matchCtrl[g*mpwm_pkg::MC_FIELD_W + mpwm_pkg::MC_RESET]
                || (g == 0 && pwmMode);
            assign stopSel[g] = matchCtrl[g*mpwm_pkg::MC_FIELD_W + mpwm_pkg::MC_STOP];
            always_ff @(posedge clk) begin
                if (rst) begin
                    shadow[g] <= mpwm_pkg::RESET_WORD;
                end else if (wrMatch && matchIdx == 3'(g)) begin
                    shadow[g] <= regWdata;
                end
            end
            // outside pwm mode a write applies at once, as in a plain timer
            always_ff @(posedge clk) begin
                if (rst) begin
                    active[g] <= mpwm_pkg::RESET_WORD;
                end else if (!pwmMode && wrMatch && matchIdx == 3'(g)) begin
                    active[g] <= regWdata;
                end else if (pwmMode && releaseMask[g] && (cycleStart || !runEn)) begin
                    active[g] <= shadow[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // release latch: set by software, cleared when applied
    // ------------------------------------------------------------
    wire logic relApply = pwmMode && (cycleStart || !runEn);
    always_ff @(posedge clk) begin
        if (rst) begin
            releaseMask <= '0;
        end else if (wrRel) begin
            releaseMask <= releaseMask | regWdata[NUM_MATCH-1:0];
        end else if (relApply) begin
            releaseMask <= '0;
        end
    end

    // ------------------------------------------------------------
    // prescaler and counter
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || cntReset || !runEn || tick) begin
            preCount <= '0;
        end else begin
            preCount <= preCount + CNT_W'(1);
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            count <= '0;
        end else if (wrCount) begin
            count <= regWdata;
        end else if (cntReset || (tick && anyReset)) begin
            count <= '0;
        end else if (tick) begin
            count <= count + CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            timerCtrl <= '0;
        end else if (wrTimer) begin
            timerCtrl <= regWdata[3:0];
        end else if (tick && anyStop) begin
            timerCtrl[mpwm_pkg::TC_ENABLE_BIT] <= 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            matchCtrl <= '0;
            prescale <= '0;
            pwmCtrl <= '0;
        end else begin
            if (wrMctl) begin
                matchCtrl <= regWdata[NUM_MATCH*mpwm_pkg::MC_FIELD_W-1:0];
            end
            if (wrPre) begin
                prescale <= regWdata;
            end
            if (wrPwm) begin
                pwmCtrl <= regWdata[15:0];
            end
        end
    end

    // flags: write one to clear, a new hit wins over the clear
    logic [NUM_MATCH-1:0] irqSel;
    generate
        for (g = 0; g < NUM_MATCH; g++) begin : gIrq
            assign irqSel[g] = matchCtrl[g*mpwm_pkg::MC_FIELD_W + mpwm_pkg::MC_IRQ];
        end
    endgenerate
    always_ff @(posedge clk) begin
        if (rst) begin
            matchFlags <= '0;
        end else begin
            matchFlags <= (matchFlags & ~(wrFlags ? regWdata[NUM_MATCH-1:0] : '0))
                | (hitEvt & irqSel);
        end
    end
    assign matchIrq = |matchFlags;

    // ------------------------------------------------------------
    // pwm channels: channel n uses match n; double edge adds match n-1
    // ------------------------------------------------------------
    generate
        for (g = 1; g <= mpwm_pkg::NUM_OUT; g++) begin : gCh
            wire logic dbl = pwmCtrl[mpwm_pkg::PC_DOUBLE_BASE + g - 1] && g > 1;
            wire logic ena = pwmCtrl[mpwm_pkg::PC_ENABLE_BASE + g - 1] && pwmMode;
            mpwm_channel uCh (
                .clk(clk),
                .rst(rst),
                .cycleStart(cycleStart),
                .setHit(hitEvt[g-1] && pwmMode),
                .clrHit(hitEvt[g] && pwmMode),
                .doubleEdge(dbl),
                .enable(ena),
                .pwmOut(pwmOut[g-1])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = '0;
        case (regAddr)
            mpwm_pkg::OFF_TIMER_CTRL: next_rdata = {28'h0000000, timerCtrl};
            mpwm_pkg::OFF_COUNT: next_rdata = count;
            mpwm_pkg::OFF_PRESCALE: next_rdata = prescale;
            mpwm_pkg::OFF_PRESCALE_CNT: next_rdata = preCount;
            mpwm_pkg::OFF_MATCH_CTRL: next_rdata = 32'(matchCtrl);
            mpwm_pkg::OFF_MATCH_FLAGS: next_rdata = 32'(matchFlags);
            mpwm_pkg::OFF_PWM_CTRL: next_rdata = {16'h0000, pwmCtrl};
            mpwm_pkg::OFF_RELEASE: next_rdata = 32'(releaseMask);
            default: begin
                if (matchArea && matchIdx < 3'(NUM_MATCH)) begin
                    next_rdata = shadow[matchIdx];
                end
            end
        endcase
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            regRdata <= '0;
        end else if (regRd) begin
            regRdata <= next_rdata;
        end else begin
            regRdata <= '0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence cycleHit;
        tick && hit[0] && pwmMode && !wrCount;
    endsequence
    cycle_wrap_a: assert property (@(posedge clk) disable iff (rst)
        cycleHit |=> count == '0)
        else $error("counter did not restart on cycle match");
    pre_step_a: assert property (@(posedge clk) disable iff (rst)
        tick && !anyReset && !wrCount |=> count == $past(count) + 1)
        else $error("counter did not step on prescale tick");
    stop_run_a: assert property (@(posedge clk) disable iff (rst)
        tick && anyStop && !wrTimer |=> !runEn)
        else $error("stop match did not halt counter");
    flag_set_a: assert property (@(posedge clk) disable iff (rst)
        |(hitEvt & irqSel) |=> matchIrq)
        else $error("interrupt flag not raised");
    release_hold_a: assert property (@(posedge clk) disable iff (rst)
        pwmMode && runEn && !cycleStart && !wrMatch && !wrTimer
        |=> active[1] == $past(active[1]))
        else $error("match value changed mid cycle");
    idle_out_a: assert property (@(posedge clk) disable iff (rst)
        !pwmMode && $past(!pwmMode) |-> pwmOut == '0)
        else $error("pwm output active outside pwm mode");
    read_once_a: assert property (@(posedge clk) disable iff (rst)
        !regRd |=> regRdata == '0)
        else $error("read data stood beyond one cycle");
    single_high_a: assert property (@(posedge clk) disable iff (rst)
        cycleStart && pwmCtrl[mpwm_pkg::PC_ENABLE_BASE] && !hitEvt[1] && !wrPwm
        && !wrTimer |=> pwmOut[0])
        else $error("single edge output not high at cycle start");
endmodule
`default_nettype wire

//--- mpwm_pkg.sv
// package: register map, field layout and reset values of the match based pwm unit
package mpwm_pkg;
    localparam int NUM_MATCH = 7;
    localparam int NUM_OUT = 6;
    localparam int CNT_W = 32;
    localparam int ADDR_W = 6;
    // ------------------------------------------------------------
    // register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [5:0] OFF_TIMER_CTRL = 6'h00;
    localparam logic [5:0] OFF_COUNT = 6'h04;
    localparam logic [5:0] OFF_PRESCALE = 6'h08;
    localparam logic [5:0] OFF_PRESCALE_CNT = 6'h0c;
    localparam logic [5:0] OFF_MATCH_CTRL = 6'h10;
    localparam logic [5:0] OFF_MATCH_FLAGS = 6'h14;
    localparam logic [5:0] OFF_PWM_CTRL = 6'h18;
    localparam logic [5:0] OFF_RELEASE = 6'h1c;
    localparam logic [5:0] OFF_MATCH_BASE = 6'h20;
    // ------------------------------------------------------------
    // timer control fields
    // ------------------------------------------------------------
    localparam int TC_ENABLE_BIT = 0;
    localparam int TC_RESET_BIT = 1;
    localparam int TC_PWM_BIT = 3;
    // match control: three bits per match register
    localparam int MC_IRQ = 0;
    localparam int MC_RESET = 1;
    localparam int MC_STOP = 2;
    localparam int MC_FIELD_W = 3;
    // pwm control: bits 2..6 double-edge select (bit 1 has no effect), bits 9..14 output enable
    localparam int PC_DOUBLE_BASE = 1;
    localparam int PC_ENABLE_BASE = 9;
    localparam logic [31:0] RESET_WORD = 32'h00000000;
endpackage

//--- mpwm_channel.sv
// module: one pwm output channel, single or double edge
`timescale 1ns/1ps
`default_nettype none
module mpwm_channel (
    input wire logic clk, // core clock
    input wire logic rst, // sync reset, active high
    input wire logic cycleStart, // cycle match hit this cycle
    input wire logic setHit, // rising-edge match hit (double edge)
    input wire logic clrHit, // falling-edge match hit
    input wire logic doubleEdge, // 1: double edge, 0: single edge
    input wire logic enable, // output enabled
    output logic pwmOut // pwm pin level
);
    logic level;
    logic next_level;
    // ------------------------------------------------------------
    // edge selection
    // ------------------------------------------------------------
    // falling match at cycle start wins so a zero-width single edge stays low
    wire logic setEvt = doubleEdge ? setHit : cycleStart;
    wire logic clrEvt = clrHit;
    always_comb begin
        next_level = level;
        if (setEvt && !clrEvt) begin
            next_level = 1'b1;
        end else if (clrEvt) begin
            next_level = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            level <= 1'b0;
        end else begin
            level <= next_level;
        end
    end
    assign pwmOut = level;

    set_rise_a: assert property (@(posedge clk) disable iff (rst)
        enable && $past(enable) && $past(setEvt) && !$past(clrEvt) |-> pwmOut)
        else $error("pwm output did not rise");
    clr_fall_a: assert property (@(posedge clk) disable iff (rst)
        $past(clrEvt) |-> !pwmOut)
        else $error("pwm output did not fall");
endmodule
`default_nettype wire

//--- mpwm_load_model.sv
// model: passive load on one pwm pin, measures pulse and period length
`timescale 1ns/1ps
`default_nettype none
module mpwm_load_model (
    input wire logic clk, // core clock
    input wire logic rst, // sync reset, active high
    input wire logic pin, // pwm level seen by the load
    output logic [31:0] highLen, // clocks high in last complete pulse
    output logic [31:0] periodLen // clocks between last two rising edges
);
    logic prevPin;
    logic [31:0] hiCnt;
    logic [31:0] perCnt;
    // a load cannot tell latency apart, so only edge-to-edge spans are kept
    always_ff @(posedge clk) begin
        if (rst) begin
            prevPin <= 1'b0;
            hiCnt <= 32'h0;
            perCnt <= 32'h0;
            highLen <= 32'h0;
            periodLen <= 32'h0;
        end else begin
            prevPin <= pin;
            perCnt <= perCnt + 32'h1;
            if (pin) begin
                hiCnt <= hiCnt + 32'h1;
            end
            if (pin && !prevPin) begin
                periodLen <= perCnt;
                perCnt <= 32'h1;
                hiCnt <= 32'h1;
            end
            if (!pin && prevPin) begin
                highLen <= hiCnt;
            end
        end
    end
endmodule
`default_nettype wire

//--- mpwm_unit_tb_top.sv
// testbench: directed scenarios for the match based pwm unit
`timescale 1ns/1ps
`default_nettype none
module mpwm_unit_tb_top;
    logic clk;
    logic rst;
    logic [5:0] regAddr;
    logic [31:0] regWdata;
    logic regWr;
    logic regRd;
    logic [31:0] regRdata;
    logic [mpwm_pkg::NUM_OUT-1:0] pwmOut;
    logic matchIrq;
    wire logic [191:0] highLen;
    wire logic [191:0] periodLen;
    logic [31:0] rdata;
    logic [31:0] firstCnt;
    int errors;
    int compares;

    mpwm_unit i_dut (
        .clk(clk),
        .rst(rst),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .regWr(regWr),
        .regRd(regRd),
        .regRdata(regRdata),
        .pwmOut(pwmOut),
        .matchIrq(matchIrq)
    );

    genvar gl;
    generate
        for (gl = 0; gl < 6; gl++) begin : gLoad
            mpwm_load_model i_load (
                .clk(clk),
                .rst(rst),
                .pin(pwmOut[gl]),
                .highLen(highLen[32*gl +: 32]),
                .periodLen(periodLen[32*gl +: 32])
            );
        end
    endgenerate

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic summarize();
        if (errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    // strobe dropped one edge later, so back-to-back calls never clash
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [5:0] a);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        rdata = regRdata;
        @(posedge clk);
    endtask

    task automatic wm(input int n, input logic [31:0] v);
        wr(mpwm_pkg::OFF_MATCH_BASE + 6'(4 * n), v);
    endtask

    task automatic chkCh(input int c, input logic [31:0] per, input logic [31:0] hi);
        chk("period", per, periodLen[32*c +: 32]);
        chk("high", hi, highLen[32*c +: 32]);
    endtask

    // stopped with pwm mode off first, so the match writes apply at once
    task automatic cfg(input int p, input int m0, input int m1, input int m2, input int pc);
        wr(mpwm_pkg::OFF_TIMER_CTRL, 32'h00000002);
        wr(mpwm_pkg::OFF_PRESCALE, 32'(p));
        wm(0, 32'(m0));
        wm(1, 32'(m1));
        wm(2, 32'(m2));
        wr(mpwm_pkg::OFF_PWM_CTRL, 32'(pc));
        wr(mpwm_pkg::OFF_RELEASE, 32'h00000007);
        wr(mpwm_pkg::OFF_TIMER_CTRL, 32'h00000009);
        repeat (60 * (p + 1)) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(mpwm_pkg::OFF_TIMER_CTRL);
        chk("ctrl", 32'h0, rdata);
        rd(mpwm_pkg::OFF_COUNT);
        chk("count", 32'h0, rdata);
        rd(mpwm_pkg::OFF_PRESCALE);
        chk("prescale", 32'h0, rdata);
        rd(mpwm_pkg::OFF_MATCH_BASE);
        chk("match0", 32'h0, rdata);
        chk("pwm", 32'h0, 32'(pwmOut));
        chk("irq", 32'h0, 32'(matchIrq));
        wr(6'h3c, 32'hffffffff);
        rd(6'h3c);
        chk("unmapped", 32'h0, rdata);
    endtask

    task automatic t_single(input int p);
        cfg(p, 9, 3, 0, 32'h00000200);
        chkCh(0, 32'(10 * (p + 1)), 32'(4 * (p + 1)));
    endtask

    // channel 1 single edge shares match 1 with channel 2's rising edge
    task automatic t_double(input int r, input int f, input int h2, input int h1);
        cfg(0, 9, r, f, 32'h00000604);
        chkCh(1, 32'h0000000a, 32'(h2));
        chkCh(0, 32'h0000000a, 32'(h1));
    endtask

    task automatic t_release();
        wm(1, 32'h00000002);
        wm(2, 32'h00000006);
        repeat (60) @(posedge clk);
        chkCh(1, 32'h0000000a, 32'h00000006);
        wr(mpwm_pkg::OFF_RELEASE, 32'h00000006);
        repeat (60) @(posedge clk);
        chkCh(1, 32'h0000000a, 32'h00000004);
        chkCh(0, 32'h0000000a, 32'h00000003);
    endtask

    // all six channels single edge, match n ends channel n after n+1 counts
    task automatic t_six();
        int c;
        wr(mpwm_pkg::OFF_TIMER_CTRL, 32'h00000002);
        wm(3, 32'h00000003);
        wm(4, 32'h00000004);
        wm(5, 32'h00000005);
        wm(6, 32'h00000006);
        cfg(0, 9, 1, 2, 32'h00007e00);
        for (c = 0; c < 6; c++) begin
            chkCh(c, 32'h0000000a, 32'(c + 2));
        end
    endtask

    task automatic t_timer();
        int i;
        wr(mpwm_pkg::OFF_TIMER_CTRL, 32'h00000002);
        wr(mpwm_pkg::OFF_MATCH_CTRL, 32'h00000a00);
        wm(3, 32'h00000005);
        wr(mpwm_pkg::OFF_TIMER_CTRL, 32'h00000001);
        for (i = 0; i < 100 && matchIrq !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        if (matchIrq !== 1'b1) begin
            chk("irq", 32'h1, 32'(matchIrq));
            summarize();
        end
        repeat (5) @(posedge clk);
        rd(mpwm_pkg::OFF_COUNT);
        // the stopping tick still advances the count by one
        chk("stop", 32'h00000006, rdata);
        rd(mpwm_pkg::OFF_TIMER_CTRL);
        chk("ctrl", 32'h0, rdata);
        chk("pwm", 32'h0, 32'(pwmOut));
        wr(mpwm_pkg::OFF_COUNT, 32'h00000003);
        rd(mpwm_pkg::OFF_COUNT);
        chk("count write", 32'h00000003, rdata);
        wr(mpwm_pkg::OFF_MATCH_FLAGS, 32'h00000008);
        chk("irq", 32'h0, 32'(matchIrq));
        wr(mpwm_pkg::OFF_TIMER_CTRL, 32'h00000002);
        wr(mpwm_pkg::OFF_MATCH_CTRL, 32'h00002000);
        wm(4, 32'h00000007);
        wr(mpwm_pkg::OFF_TIMER_CTRL, 32'h00000001);
        repeat (40) @(posedge clk);
        rd(mpwm_pkg::OFF_COUNT);
        firstCnt = rdata;
        rd(mpwm_pkg::OFF_COUNT);
        chk("wrap", (firstCnt + 32'h2) & 32'h7, rdata);
        chk("irq", 32'h0, 32'(matchIrq));
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        regAddr = 6'h00;
        regWdata = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        errors = 0;
        compares = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_single(0);
        t_single(1);
        t_double(2, 6, 4, 3);
        t_double(6, 2, 6, 7);
        t_release();
        t_six();
        t_timer();
        summarize();
    end

    // hang guard well beyond the longest scenario
    initial begin
        #200000;
        errors++;
        summarize();
    end
endmodule
`default_nettype wire
